// ### core/mmp_map_ports.sv
`timescale 1ns/10ps
`default_nettype none
module mmp_map_ports (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] prog_addr,
	output var mmp_pkg::mmp_prog_rsp_type prog_rsp,
	input wire mmp_pkg::mmp_reg_req_type reg_req,
	output var mmp_pkg::mmp_reg_rsp_type reg_rsp,
	input wire logic set_pointer_instruction,
	input wire logic [7:0] set_pointer_value,
	output logic [7:0] reg_pointer,
	output logic [7:0] p0_o,
	output logic [7:0] p0_oe_n,
	output logic [7:0] p1_o,
	output logic [7:0] p1_oe_n,
	input wire logic [7:0] p2_i,
	output logic [7:0] p2_o,
	output logic [7:0] p2_oe_n,
	input wire logic [3:0] port3_fixed_inputs,
	output logic [3:0] port3_fixed_outputs,
	input wire logic [2:0] ext_irq_enable,
	output logic [2:0] external_interrupt_requests
);
	mmp_pkg::mmp_state_type st_ff;
	mmp_pkg::mmp_state_type nxt_st;
	logic [7:0] eff_addr;
	mmp_pkg::mmp_region_type region;

	function automatic mmp_pkg::mmp_region_type decode_region(input logic [7:0] a,
			input logic [3:0] bank);
		mmp_pkg::mmp_region_type r;
		r = mmp_pkg::RG_NONE;
		if (bank != mmp_pkg::BANK_NORM && a <= mmp_pkg::BANK_LOW_TOP) begin
			if (bank == mmp_pkg::BANK_USB && a <= mmp_pkg::USB_TOP) begin
				r = mmp_pkg::RG_USB;
			end
		end else if (a <= mmp_pkg::PORT_TOP) begin
			r = mmp_pkg::RG_PORT;
		end else if (a <= mmp_pkg::GPR_TOP) begin
			r = mmp_pkg::RG_GPR;
		end else if (a >= mmp_pkg::CTRL_BASE) begin
			r = mmp_pkg::RG_CTRL;
		end
		return r;
	endfunction

	// Short form replaces the low nibble only; group start is the pointer's high nibble
	assign eff_addr = reg_req.short_mode ? {st_ff.ptr[7:4], reg_req.addr[3:0]}
		: reg_req.addr;
	assign region = decode_region(eff_addr, st_ff.ptr[3:0]);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.p2_s1 = p2_i;
		nxt_st.p2_s2 = st_ff.p2_s1;
		nxt_st.p3_s1 = port3_fixed_inputs;
		nxt_st.p3_s2 = st_ff.p3_s1;
		nxt_st.p3_s3 = st_ff.p3_s2;
		// Edge taken behind the synchroniser so a metastable first stage never reaches logic
		nxt_st.irq = st_ff.p3_s3[3:1] & ~st_ff.p3_s2[3:1] & ext_irq_enable;
		if (set_pointer_instruction) begin
			nxt_st.ptr = set_pointer_value;
		end
		if (prog_addr < mmp_pkg::VEC_BYTES) begin
			nxt_st.prog.region = mmp_pkg::PM_VEC;
		end else if (prog_addr < mmp_pkg::PROG_SIZE) begin
			nxt_st.prog.region = mmp_pkg::PM_ROM;
		end else begin
			nxt_st.prog.region = mmp_pkg::PM_RSV;
		end
		nxt_st.prog.vector = prog_addr[3:1];
		nxt_st.prog.high_byte = ~prog_addr[0];
		nxt_st.prog.rom_index = prog_addr[11:0];
		nxt_st.rsp.valid = reg_req.valid;
		nxt_st.rsp.region = region;
		nxt_st.rsp.index = eff_addr;
		nxt_st.rsp.rdata = 8'h00;
		if (reg_req.valid) begin
			case (region)
				mmp_pkg::RG_PORT: begin
					case (eff_addr[1:0])
						2'h0: nxt_st.rsp.rdata = st_ff.p0;
						2'h1: nxt_st.rsp.rdata = st_ff.p1;
						2'h2: nxt_st.rsp.rdata = st_ff.p2_s2;
						default: nxt_st.rsp.rdata = {st_ff.p3_out, st_ff.p3_s2};
					endcase
					if (reg_req.write) begin
						case (eff_addr[1:0])
							2'h0: nxt_st.p0 = reg_req.wdata;
							2'h1: nxt_st.p1 = reg_req.wdata;
							2'h2: nxt_st.p2_out = reg_req.wdata;
							default: nxt_st.p3_out = reg_req.wdata[7:4];
						endcase
					end
				end
				mmp_pkg::RG_CTRL: begin
					if (reg_req.write && eff_addr == mmp_pkg::P2_MODE_ADDR) begin
						nxt_st.p2_dir = reg_req.wdata[7:4];
					end
				end
				mmp_pkg::RG_NONE: nxt_st.rsp.rdata = mmp_pkg::UNIMPL_RDATA;
				default: nxt_st.rsp.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.ptr <= mmp_pkg::PTR_RST;
			st_ff.p0 <= mmp_pkg::OD_LATCH_RST;
			st_ff.p1 <= mmp_pkg::OD_LATCH_RST;
			st_ff.p2_dir <= mmp_pkg::P2_DIR_RST;
			st_ff.p3_out <= mmp_pkg::P3_OUT_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prog_rsp = st_ff.prog;
	assign reg_rsp = st_ff.rsp;
	assign reg_pointer = st_ff.ptr;
	// Open drain: a zero latch bit pulls low, a one releases the line
	assign p0_o = 8'h00;
	assign p0_oe_n = st_ff.p0;
	assign p1_o = 8'h00;
	assign p1_oe_n = st_ff.p1;
	assign p2_o = st_ff.p2_out;
	// Direction bit one means input; lower nibble is never driven
	assign p2_oe_n = {st_ff.p2_dir, 4'hf};
	assign port3_fixed_outputs = st_ff.p3_out;
	assign external_interrupt_requests = st_ff.irq;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	property p_prog_vec;
		prog_addr < 16'h000c |=> prog_rsp.region == mmp_pkg::PM_VEC
			&& prog_rsp.vector == $past(prog_addr[3:1]);
	endproperty
	a_prog_vec: assert property (p_prog_vec) else $error("vector decode wrong");
	property p_prog_rom;
		prog_addr >= 16'h000c && prog_addr <= 16'h0fff |=> prog_rsp.region == mmp_pkg::PM_ROM
			&& prog_rsp.rom_index == $past(prog_addr[11:0]);
	endproperty
	a_prog_rom: assert property (p_prog_rom) else $error("rom decode wrong");
	property p_prog_rsv;
		prog_addr >= 16'h1000 |=> prog_rsp.region == mmp_pkg::PM_RSV;
	endproperty
	a_prog_rsv: assert property (p_prog_rsv) else $error("reserved decode wrong");
	property p_short;
		reg_req.valid && reg_req.short_mode
			|=> reg_rsp.index == {$past(st_ff.ptr[7:4]), $past(reg_req.addr[3:0])};
	endproperty
	a_short: assert property (p_short) else $error("short address wrong");
	property p_usb;
		reg_req.valid && !reg_req.short_mode && st_ff.ptr[3:0] == 4'h1
			&& reg_req.addr <= 8'h07 |=> reg_rsp.region == mmp_pkg::RG_USB;
	endproperty
	a_usb: assert property (p_usb) else $error("usb window missing");
	property p_port;
		reg_req.valid && !reg_req.short_mode && st_ff.ptr[3:0] == 4'h0
			&& reg_req.addr <= 8'h03 |=> reg_rsp.region == mmp_pkg::RG_PORT;
	endproperty
	a_port: assert property (p_port) else $error("port decode wrong");
	property p_gpr;
		reg_req.valid && !reg_req.short_mode && reg_req.addr >= 8'h10
			&& reg_req.addr <= 8'hbf |=> reg_rsp.region == mmp_pkg::RG_GPR;
	endproperty
	a_gpr: assert property (p_gpr) else $error("general area wrong");
	property p_gap;
		reg_req.valid && !reg_req.short_mode && reg_req.addr >= 8'hc0 && reg_req.addr < 8'hf0
			|=> reg_rsp.region == mmp_pkg::RG_NONE && reg_rsp.rdata == 8'hff
			&& $stable(st_ff.p2_dir) && $stable(st_ff.p0);
	endproperty
	a_gap: assert property (p_gap) else $error("gap access leaked");
	property p_open_drain;
		p0_o == 8'h00 && p1_o == 8'h00 && p0_oe_n == st_ff.p0 && p2_oe_n[3:0] == 4'hf;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin drive wrong");
	// Synchronisers restart from zero, so a fall seen on the first edge after reset is not one
	property p_irq;
		$fell(port3_fixed_inputs[1]) && !$past(rst) ##2 ext_irq_enable[0]
			|=> external_interrupt_requests[0];
	endproperty
	a_irq: assert property (p_irq) else $error("external request lost");
	property p_irq_cause;
		external_interrupt_requests[2] |-> $past(ext_irq_enable[2]) && $past(st_ff.p3_s3[3])
			&& !$past(st_ff.p3_s2[3]);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("spurious request");
	property p_irq_once;
		external_interrupt_requests[0] |=> !external_interrupt_requests[0];
	endproperty
	a_irq_once: assert property (p_irq_once) else $error("request pulse too long");
	property p_p2_dir;
		reg_req.valid && reg_req.write && !reg_req.short_mode && reg_req.addr == 8'hf6
			|=> p2_oe_n == {$past(reg_req.wdata[7:4]), 4'hf};
	endproperty
	a_p2_dir: assert property (p_p2_dir) else $error("port two direction wrong");
	property p_p3_out;
		reg_req.valid && reg_req.write && !reg_req.short_mode && st_ff.ptr[3:0] == 4'h0
			&& reg_req.addr == 8'h03 |=> port3_fixed_outputs == $past(reg_req.wdata[7:4]);
	endproperty
	a_p3_out: assert property (p_p3_out) else $error("port three latch wrong");
	property p_ptr_load;
		set_pointer_instruction |=> reg_pointer == $past(set_pointer_value);
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("pointer load wrong");

	c_usb: cover property (reg_req.valid && region == mmp_pkg::RG_USB);
	c_short: cover property (reg_req.valid && reg_req.short_mode ##1 reg_rsp.valid);
	c_irq: cover property (external_interrupt_requests != 3'h0);
	c_rsv: cover property (prog_rsp.region == mmp_pkg::PM_RSV);
endmodule // mmp_map_ports
`default_nettype wire

// ### common/mmp_pkg.sv
`default_nettype none
package mmp_pkg;
	localparam logic [15:0] PROG_SIZE = 16'h1000;
	localparam logic [15:0] VEC_BYTES = 16'h000c;
	localparam logic [7:0] PORT_TOP = 8'h03;
	localparam logic [7:0] GPR_TOP = 8'hbf;
	localparam logic [7:0] CTRL_BASE = 8'hf0;
	localparam logic [7:0] USB_TOP = 8'h07;
	localparam logic [7:0] BANK_LOW_TOP = 8'h0f;
	localparam logic [7:0] P2_MODE_ADDR = 8'hf6;
	localparam logic [7:0] UNIMPL_RDATA = 8'hff;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] OD_LATCH_RST = 8'hff;
	localparam logic [3:0] P2_DIR_RST = 4'hf;
	localparam logic [3:0] P3_OUT_RST = 4'hf;
	localparam logic [3:0] BANK_NORM = 4'h0;
	localparam logic [3:0] BANK_USB = 4'h1;

	typedef enum logic [2:0] {
		RG_PORT = 3'b000,
		RG_GPR = 3'b001,
		RG_CTRL = 3'b011,
		RG_USB = 3'b010,
		RG_NONE = 3'b110
	} mmp_region_type;

	typedef enum logic [1:0] {
		PM_VEC = 2'b00,
		PM_ROM = 2'b01,
		PM_RSV = 2'b11
	} mmp_prog_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic short_mode;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mmp_reg_req_type;

	typedef struct packed {
		logic valid;
		mmp_region_type region;
		logic [7:0] index;
		logic [7:0] rdata;
	} mmp_reg_rsp_type;

	typedef struct packed {
		mmp_prog_type region;
		logic [2:0] vector;
		logic high_byte;
		logic [11:0] rom_index;
	} mmp_prog_rsp_type;

	typedef struct packed {
		logic [7:0] ptr;
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2_out;
		logic [3:0] p2_dir;
		logic [3:0] p3_out;
		logic [7:0] p2_s1;
		logic [7:0] p2_s2;
		logic [3:0] p3_s1;
		logic [3:0] p3_s2;
		logic [3:0] p3_s3;
		logic [2:0] irq;
		mmp_reg_rsp_type rsp;
		mmp_prog_rsp_type prog;
	} mmp_state_type;
endpackage
`default_nettype wire

// ### test/mmp_map_ports_test.sv
`timescale 1ns/10ps
`default_nettype none
module mmp_map_ports_test;
	typedef struct packed {
		logic [15:0] pa;
		mmp_pkg::mmp_prog_type pr;
		logic [7:0] ra;
		mmp_pkg::mmp_region_type rr;
		logic [7:0] rd;
	} mmp_row_type;
	localparam mmp_row_type ROWS [8] = '{
		'{16'h0000, mmp_pkg::PM_VEC, 8'h00, mmp_pkg::RG_PORT, 8'hff},
		'{16'h000b, mmp_pkg::PM_VEC, 8'h01, mmp_pkg::RG_PORT, 8'hff},
		'{16'h000c, mmp_pkg::PM_ROM, 8'h04, mmp_pkg::RG_GPR, 8'h00},
		'{16'h0fff, mmp_pkg::PM_ROM, 8'hbf, mmp_pkg::RG_GPR, 8'h00},
		'{16'h1000, mmp_pkg::PM_RSV, 8'hc0, mmp_pkg::RG_NONE, 8'hff},
		'{16'hffff, mmp_pkg::PM_RSV, 8'hef, mmp_pkg::RG_NONE, 8'hff},
		'{16'h0005, mmp_pkg::PM_VEC, 8'hf0, mmp_pkg::RG_CTRL, 8'h00},
		'{16'h0800, mmp_pkg::PM_ROM, 8'hff, mmp_pkg::RG_CTRL, 8'h00}
	};
	logic ref_clk, rst, set_pointer_instruction;
	logic [15:0] prog_addr;
	mmp_pkg::mmp_prog_rsp_type prog_rsp;
	mmp_pkg::mmp_reg_req_type reg_req;
	mmp_pkg::mmp_reg_rsp_type reg_rsp;
	logic [7:0] set_pointer_value, reg_pointer, p0_o, p0_oe_n, p1_o, p1_oe_n, p2_i, p2_o, p2_oe_n;
	logic [3:0] port3_fixed_inputs, port3_fixed_outputs;
	logic [2:0] ext_irq_enable, external_interrupt_requests;
	int errors = 0;
	int compares = 0;
	int n;
	mmp_map_ports dut (.ref_clk(ref_clk), .rst(rst), .prog_addr(prog_addr), .prog_rsp(prog_rsp),
		.reg_req(reg_req), .reg_rsp(reg_rsp), .set_pointer_instruction(set_pointer_instruction),
		.set_pointer_value(set_pointer_value), .reg_pointer(reg_pointer), .p0_o(p0_o),
		.p0_oe_n(p0_oe_n), .p1_o(p1_o), .p1_oe_n(p1_oe_n), .p2_i(p2_i), .p2_o(p2_o),
		.p2_oe_n(p2_oe_n), .port3_fixed_inputs(port3_fixed_inputs),
		.port3_fixed_outputs(port3_fixed_outputs), .ext_irq_enable(ext_irq_enable),
		.external_interrupt_requests(external_interrupt_requests));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request stands for one edge; checks follow at the next falling edge, after valid is dropped
	task automatic acc(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_req = '{1'b1, w, s, a, d};
		@(negedge ref_clk);
		reg_req.valid = 1'b0;
		chk(reg_rsp.valid, 1'b1);
	endtask
	task automatic setp(input logic [7:0] v);
		@(negedge ref_clk);
		set_pointer_instruction = 1'b1;
		set_pointer_value = v;
		@(negedge ref_clk);
		set_pointer_instruction = 1'b0;
		chk(reg_pointer, v);
	endtask
	// Falls the given pins and counts pulses on one request line over six cycles
	task automatic fall(input logic [3:0] pins, input int b, output int cnt);
		cnt = 0;
		@(negedge ref_clk);
		port3_fixed_inputs = pins;
		repeat (6) begin
			@(negedge ref_clk);
			cnt += int'(external_interrupt_requests[b] === 1'b1);
		end
		port3_fixed_inputs = 4'hf;
		repeat (6) @(negedge ref_clk);
	endtask
	task automatic summarize();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		prog_addr = 16'h0000;
		reg_req = '0;
		set_pointer_instruction = 1'b0;
		set_pointer_value = 8'h00;
		p2_i = 8'h3c;
		port3_fixed_inputs = 4'hf;
		ext_irq_enable = 3'h7;
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		chk(reg_pointer, 8'h00);
		chk({p0_oe_n, p1_oe_n}, 16'hffff);
		chk({p2_oe_n, 4'h0, port3_fixed_outputs}, 16'hff0f);
		foreach (ROWS[i]) begin
			prog_addr = ROWS[i].pa;
			acc(1'b0, 1'b0, ROWS[i].ra, 8'h00);
			chk(prog_rsp.region, ROWS[i].pr);
			chk({reg_rsp.region, reg_rsp.index}, {ROWS[i].rr, ROWS[i].ra});
			chk(reg_rsp.rdata, ROWS[i].rd);
		end
		chk({prog_rsp.vector, prog_rsp.high_byte}, 4'h1);
		chk(prog_rsp.rom_index, 16'h0800);
		prog_addr = 16'h0005;
		@(negedge ref_clk);
		chk({prog_rsp.vector, prog_rsp.high_byte}, 4'h4);
		// Writes to the gap must not disturb the fixed undefined read value
		acc(1'b1, 1'b0, 8'hc0, 8'h12);
		acc(1'b0, 1'b0, 8'hc0, 8'h00);
		chk(reg_rsp.rdata, 8'hff);
		acc(1'b1, 1'b0, 8'h00, 8'h5a);
		chk({p0_oe_n, p0_o}, 16'h5a00);
		acc(1'b1, 1'b0, 8'h01, 8'ha5);
		chk({p1_oe_n, p1_o}, 16'ha500);
		acc(1'b1, 1'b0, 8'hf6, 8'h30);
		chk(p2_oe_n, 8'h3f);
		acc(1'b1, 1'b0, 8'h02, 8'h96);
		chk(p2_o, 8'h96);
		acc(1'b0, 1'b0, 8'h02, 8'h00);
		chk(reg_rsp.rdata, 8'h3c);
		acc(1'b1, 1'b0, 8'h03, 8'ha0);
		chk(port3_fixed_outputs, 4'ha);
		acc(1'b0, 1'b0, 8'h03, 8'h00);
		chk(reg_rsp.rdata, 8'haf);
		setp(8'h21);
		acc(1'b0, 1'b1, 8'h05, 8'h00);
		chk({reg_rsp.region, reg_rsp.index}, {mmp_pkg::RG_GPR, 8'h25});
		acc(1'b0, 1'b0, 8'h00, 8'h00);
		chk(reg_rsp.region, mmp_pkg::RG_USB);
		acc(1'b0, 1'b0, 8'h07, 8'h00);
		chk(reg_rsp.region, mmp_pkg::RG_USB);
		acc(1'b0, 1'b0, 8'h08, 8'h00);
		chk(reg_rsp.region, mmp_pkg::RG_NONE);
		acc(1'b0, 1'b0, 8'h10, 8'h00);
		chk(reg_rsp.region, mmp_pkg::RG_GPR);
		setp(8'h00);
		acc(1'b0, 1'b0, 8'h03, 8'h00);
		chk(reg_rsp.region, mmp_pkg::RG_PORT);
		for (int b = 0; b < 3; b++) begin
			fall(4'hf ^ (4'h2 << b), b, n);
			chk(16'(n), 16'h0001);
		end
		// Line one masked alone while its neighbours fire
		ext_irq_enable = 3'h5;
		fall(4'h1, 1, n);
		chk(16'(n), 16'h0000);
		// The lowest fixed input is not an interrupt source
		ext_irq_enable = 3'h7;
		fall(4'he, 0, n);
		chk(16'(n), 16'h0000);
		// Mid-run reset must drop the pointer and port latches back to their idle values
		setp(8'h31);
		rst = 1'b1;
		@(negedge ref_clk);
		rst = 1'b0;
		chk({reg_pointer, p0_oe_n}, 16'h00ff);
		chk({p2_oe_n, 4'h0, port3_fixed_outputs}, 16'hff0f);
		summarize();
	end
endmodule // mmp_map_ports_test
`default_nettype wire
